// file: design/swd_pkg.sv
package swd_pkg;

    // Serial frame layout
    localparam int FRAME_BITS     = 16;
    localparam int WE_BIT         = 15;
    localparam int FAULT_STATUS_BIT_POS      = 6;
    localparam int SLEEP_POS      = 5;
    localparam int SHDIS_POS      = 4;
    localparam int COMPDIS_POS    = 3;
    localparam int PUMPEN_POS     = 1;
    localparam int STATE_BITS     = 4;

    // APB map
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATE  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // Reset values
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] STATE_RESET = 8'h00;

    // Routes for host use
    localparam logic [3:0] ROUTE_OPEN   = 4'h0;
    localparam logic [3:0] ROUTE_HS     = 4'h3;
    localparam logic [3:0] ROUTE_LS     = 4'h5;
    localparam logic [3:0] ROUTE_HS_LS  = 4'h6;
    localparam logic [3:0] ROUTE_MS     = 4'h9;
    localparam logic [3:0] ROUTE_HS_MS  = 4'hA;
    localparam logic [3:0] ROUTE_MS_LS  = 4'hC;
    localparam logic [3:0] ROUTE_CLOSED = 4'hF;

    typedef struct packed {
        logic       sck;
        logic       sdi;
        logic       cs_n;
        logic       mode_sel;
        logic       flip_sel;
        logic       pump_enable_pin;
        logic       shutdown_disable_pin;
        logic       logic_uv;
        logic       pump_uv;
        logic       logic_armed;
        logic       pump_armed;
    } pins_t;

    typedef struct packed {
        logic [FRAME_BITS-1:0] shift;
        logic [FRAME_BITS-1:0] held;
        logic                  sck_d;
        logic                  cs_d;
        logic                  sdo;
        logic                  load;
        logic [7:0]            ld_ctrl;
        logic [7:0]            ld_state;
    } spi_t;

endpackage : swd_pkg

// file: design/pin_sync.sv
module pin_sync #(
    parameter int W = 11
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : pin_sync

// file: design/spi_shift.sv
module spi_shift (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // Synchronised link pins
    input  wire logic            sck,
    input  wire logic            sdi,
    input  wire logic            cs_n,
    // Register image shifted out
    input  wire logic [7:0]      cur_ctrl,
    input  wire logic [7:0]      cur_state,
    // Result
    output swd_pkg::spi_t        st
);
    swd_pkg::spi_t r, n;

    assign st = r;

    always_comb begin
        n = r;
        n.sck_d = sck;
        n.cs_d  = cs_n;
        n.load  = 1'b0;
        if (r.cs_d && !cs_n) begin
            n.held = {1'b0, cur_ctrl[6:0], cur_state};
            n.sdo  = n.held[swd_pkg::FRAME_BITS-1];
            n.shift = '0;
        end else if (!cs_n && sck && !r.sck_d) begin
            n.shift = {r.shift[swd_pkg::FRAME_BITS-2:0], sdi};
        end else if (!cs_n && !sck && r.sck_d) begin
            n.held = {r.held[swd_pkg::FRAME_BITS-2:0], r.shift[0]};
            n.sdo  = n.held[swd_pkg::FRAME_BITS-1];
        end
        if (!r.cs_d && cs_n && r.shift[swd_pkg::WE_BIT]) begin
            n.load     = 1'b1;
            n.ld_ctrl  = r.shift[15:8];
            n.ld_state = r.shift[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r      <= '0;
            r.cs_d <= 1'b1;
        end else begin
            r <= n;
        end
    end
endmodule : spi_shift

// file: design/switch_fault_ctrl.sv
// Local design decisions: the placing of the registers and the APB register port.
module switch_fault_ctrl (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link, input pins double as parallel controls
    input  wire logic        sck,
    input  wire logic        sdi,
    input  wire logic        chip_select_n,
    output logic             sdo,
    // Mode and control pins
    input  wire logic        mode_sel,
    input  wire logic        flip_sel,
    input  wire logic        pump_enable_pin,
    input  wire logic        shutdown_disable_pin,
    // Supply comparators
    input  wire logic        logic_uv,
    input  wire logic        pump_uv,
    input  wire logic        logic_armed,
    input  wire logic        pump_armed,
    // Outputs
    output logic             hv_out_a,
    output logic             hv_out_b,
    output logic             hv_out_c,
    output logic             hv_out_d,
    output logic             fault_out_n_o,
    output logic             fault_out_n_oe,
    output logic             pump_on
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  state;
        logic        fault_status_bit;
        logic        shut;
        logic        armed;
        logic        pen_d;
        logic [3:0]  hv;
        logic        flt_oe;
        logic        pump;
        logic        sdo;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } core_t;

    core_t r, n;
    swd_pkg::pins_t raw, sy;
    swd_pkg::spi_t  sp;

    assign raw = '{sck, sdi, chip_select_n, mode_sel, flip_sel, pump_enable_pin,
                   shutdown_disable_pin, logic_uv, pump_uv, logic_armed, pump_armed};

    pin_sync #(.W($bits(swd_pkg::pins_t))) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw),
        .q       (sy)
    );

    spi_shift u_spi (
        .pclk      (pclk),
        .presetn   (presetn),
        .sck       (sy.sck),
        .sdi       (sy.sdi),
        .cs_n      (sy.cs_n),
        .cur_ctrl  ({r.ctrl[7], r.fault_status_bit, r.ctrl[5:0]}),
        .cur_state (r.state),
        .st        (sp)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic par_mode, pump_req, sh_dis, comp_dis, fault_now;
    logic [3:0] par_code;

    assign par_mode = sy.mode_sel && !sy.flip_sel;
    assign par_code = {sy.cs_n, sy.sdi, sy.sck, 1'b0} | {3'b000, sdo_pin_dummy()};

    function automatic logic sdo_pin_dummy();
        return 1'b0;
    endfunction : sdo_pin_dummy

    assign pump_req = par_mode ? sy.pump_enable_pin : r.ctrl[swd_pkg::PUMPEN_POS];
    assign sh_dis   = par_mode ? sy.shutdown_disable_pin : r.ctrl[swd_pkg::SHDIS_POS];
    assign comp_dis = par_mode ? !sy.pump_enable_pin : r.ctrl[swd_pkg::COMPDIS_POS];
    assign fault_now = r.armed && (sy.logic_uv || (sy.pump_uv && !comp_dis));

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        n.pen_d   = pump_req;
        // Arm only after both supplies up
        if (sy.logic_armed && sy.pump_armed)
            n.armed = 1'b1;
        if (sp.load && !par_mode) begin
            n.ctrl  = sp.ld_ctrl;
            n.state = {4'h0, sp.ld_state[3:0]};
            if (!sp.ld_ctrl[swd_pkg::FAULT_STATUS_BIT_POS - 0 - 0 + 0 - 0])
                n.fault_status_bit = 1'b0;
        end
        // APB access
        if (psel && penable && !r.pready) begin
            n.pready = 1'b1;
            unique case (paddr)
                swd_pkg::ADDR_CTRL: begin
                    n.prdata = {24'h0, r.ctrl[7], r.fault_status_bit, r.ctrl[5:0]};
                    if (pwrite) begin
                        n.ctrl = pwdata[7:0];
                        if (!pwdata[swd_pkg::FAULT_STATUS_BIT_POS])
                            n.fault_status_bit = 1'b0;
                    end
                end
                swd_pkg::ADDR_STATE: begin
                    n.prdata = {24'h0, r.state};
                    if (pwrite)
                        n.state = {4'h0, pwdata[3:0]};
                end
                swd_pkg::ADDR_STATUS: begin
                    n.prdata = {26'h0, par_mode, r.armed, r.shut, r.flt_oe, r.pump,
                                r.fault_status_bit};
                end
                default: begin
                    n.prdata  = 32'h0000_0000;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        // Fault sets status, set wins over clear
        if (fault_now)
            n.fault_status_bit = 1'b1;
        if (fault_now && !sh_dis)
            n.shut = 1'b1;
        // Restart on pump enable rise after low
        else if (r.shut && pump_req && !r.pen_d && !fault_now)
            n.shut = 1'b0;
        // OR of faults drives pin, released when clear
        n.flt_oe = fault_now;
        n.hv   = n.shut ? 4'h0 : (par_mode ? par_code : n.state[3:0]);
        n.pump = pump_req && !n.shut;
        n.sdo  = par_mode ? 1'b0 : sp.sdo;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            r <= '0;
        else
            r <= n;
    end

    assign hv_out_a       = r.hv[0];
    assign hv_out_b       = r.hv[1];
    assign hv_out_c       = r.hv[2];
    assign hv_out_d       = r.hv[3];
    assign fault_out_n_o  = 1'b0;
    assign fault_out_n_oe = r.flt_oe;
    assign pump_on        = r.pump;
    assign sdo            = r.sdo;
    assign prdata         = r.prdata;
    assign pready         = r.pready;
    assign pslverr        = r.pslverr;

    ////////////////////////////////////////////////////////////////////////////
    // Shutdown opens switches
    chk_shut_opens: assert property (@(posedge pclk) disable iff (!presetn)
        r.shut |-> r.hv == 4'h0 && !r.pump) else $error("outputs live during shutdown");
    chk_fault_unarmed: assert property (@(posedge pclk) disable iff (!presetn)
        !r.armed |=> !r.flt_oe) else $error("fault pin driven before arming");
    chk_fault_sets: assert property (@(posedge pclk) disable iff (!presetn)
        fault_now |=> r.flt_oe && r.fault_status_bit) else $error("fault not flagged");
    chk_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        r.fault_status_bit && !(psel && penable && pwrite) && !sp.load
        |=> r.fault_status_bit) else $error("status bit dropped");
    chk_report_only: assert property (@(posedge pclk) disable iff (!presetn)
        !r.shut && sh_dis |=> !r.shut) else $error("shutdown while disabled");
    chk_par_drive: assert property (@(posedge pclk) disable iff (!presetn)
        par_mode && !n.shut |=> r.hv == $past(par_code)) else $error("bad parallel drive");
    chk_pin_release: assert property (@(posedge pclk) disable iff (!presetn)
        !fault_now |=> !r.flt_oe) else $error("fault pin stuck");
    chk_we_load: assert property (@(posedge pclk) disable iff (!presetn)
        sp.load |-> sp.ld_ctrl[7]) else $error("load without write enable");
endmodule : switch_fault_ctrl

// file: verification/spi_host.sv
module spi_host (
    // Clock
    input  wire logic pclk,
    // Link pins
    output logic      sck,
    output logic      sdi,
    output logic      cs_n,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle link: clock low, select high, data pulled down
    initial begin
        sck  = 1'b0;
        sdi  = 1'b0;
        cs_n = 1'b1;
    end

    // Chain output fed back to host
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge pclk);
        cs_n <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int i = 15; i >= 0; i--) begin
            sdi <= tx[i];
            // Output bit settles four cycles after the falling edge
            repeat (5) @(posedge pclk);
            rx[i] = sdo;
            sck <= 1'b1;
            repeat (3) @(posedge pclk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        cs_n <= 1'b1;
        sdi  <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : xfer

    // Pins double as parallel controls two to four
    task automatic set_pins(input logic [2:0] c);
        @(posedge pclk);
        sck  <= c[0];
        sdi  <= c[1];
        cs_n <= c[2];
    endtask : set_pins
endmodule : spi_host

// file: verification/switch_fault_ctrl_test.sv
module switch_fault_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sdo, err;
    logic        sck, sdi, cs_n, mode_sel, flip_sel, pump_pin, shdis_pin, pump_on;
    logic        logic_uv, pump_uv, logic_armed, pump_armed, flt_o, flt_oe;
    logic        hv_a, hv_b, hv_c, hv_d;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] rx;
    int          fails, n_tests;
    wire  [3:0]  hv = {hv_d, hv_c, hv_b, hv_a};

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    switch_fault_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck(sck), .sdi(sdi), .chip_select_n(cs_n), .sdo(sdo),
        .mode_sel(mode_sel), .flip_sel(flip_sel), .pump_enable_pin(pump_pin),
        .shutdown_disable_pin(shdis_pin), .logic_uv(logic_uv), .pump_uv(pump_uv),
        .logic_armed(logic_armed), .pump_armed(pump_armed), .hv_out_a(hv_a),
        .hv_out_b(hv_b), .hv_out_c(hv_c), .hv_out_d(hv_d), .fault_out_n_o(flt_o),
        .fault_out_n_oe(flt_oe), .pump_on(pump_on));

    spi_host host (.pclk(pclk), .sck(sck), .sdi(sdi), .cs_n(cs_n), .sdo(sdo));

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input string w, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %0h seen %0h", w, exp, got);
            fails++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fails++;
            summarize();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string w);
        apb(1'b0, a, 32'h0);
        chk(w, exp, rd);
    endtask : rdchk

    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask : settle

    initial begin
        #3000000;
        fails++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, mode_sel, flip_sel, pump_pin} = 7'h00;
        {logic_uv, pump_uv, logic_armed, pump_armed} = 4'h0;
        shdis_pin = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(swd_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
        rdchk(swd_pkg::ADDR_STATE, 32'h0, "state reset");
        apb(1'b0, 8'h0C, 32'h0);
        chk("slverr", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        chk("fault pin level", 1'b0, flt_o);
        @(posedge pclk) logic_uv <= 1'b1;
        settle();
        chk("unarmed pin", 1'b0, flt_oe);
        @(posedge pclk) logic_uv <= 1'b0;
        host.xfer(16'h8209, rx);
        chk("spi state", 4'h9, hv);
        chk("spi pump", 1'b1, pump_on);
        rdchk(swd_pkg::ADDR_CTRL, 32'h82, "ctrl after spi");
        host.xfer(16'h0006, rx);
        chk("shift out", 15'h0209, rx[14:0]);
        chk("no write", 4'h9, hv);
        @(posedge pclk) {logic_armed, pump_armed} <= 2'b11;
        settle();
        chk("armed idle", 1'b0, flt_oe);
        @(posedge pclk) pump_uv <= 1'b1;
        settle();
        chk("pump fault pin", 1'b1, flt_oe);
        chk("shut hv", 4'h0, hv);
        chk("shut pump", 1'b0, pump_on);
        @(posedge pclk) logic_uv <= 1'b1;
        @(posedge pclk) pump_uv <= 1'b0;
        settle();
        chk("persist", 1'b1, flt_oe);
        @(posedge pclk) logic_uv <= 1'b0;
        settle();
        chk("pin release", 1'b0, flt_oe);
        apb(1'b0, swd_pkg::ADDR_CTRL, 32'h0);
        chk("fault_status_bit latched", 1'b1, rd[swd_pkg::FAULT_STATUS_BIT_POS]);
        chk("still shut", 1'b0, pump_on);
        apb(1'b1, swd_pkg::ADDR_CTRL, 32'h00);
        apb(1'b1, swd_pkg::ADDR_CTRL, 32'h02);
        settle();
        chk("restart pump", 1'b1, pump_on);
        rdchk(swd_pkg::ADDR_CTRL, 32'h02, "fault_status_bit cleared");
        apb(1'b1, swd_pkg::ADDR_STATE, 32'h0C);
        apb(1'b1, swd_pkg::ADDR_CTRL, 32'h12);
        @(posedge pclk) logic_uv <= 1'b1;
        settle();
        chk("report pin", 1'b1, flt_oe);
        chk("report hv", 4'hC, hv);
        chk("report pump", 1'b1, pump_on);
        @(posedge pclk) logic_uv <= 1'b0;
        apb(1'b1, swd_pkg::ADDR_CTRL, 32'h1A);
        @(posedge pclk) pump_uv <= 1'b1;
        settle();
        chk("comp off serial", 1'b0, flt_oe);
        rdchk(swd_pkg::ADDR_CTRL, 32'h1A, "no fault_status_bit");
        @(posedge pclk) pump_uv <= 1'b0;
        @(posedge pclk) {mode_sel, pump_pin} <= 2'b11;
        for (int c = 0; c < 16; c += 2) begin
            host.set_pins(c[3:1]);
            settle();
            chk("parallel hv", c[3:0], hv);
        end
        @(posedge pclk) flip_sel <= 1'b1;
        settle();
        chk("flip blocks", 4'hC, hv);
        @(posedge pclk) {flip_sel, pump_pin, pump_uv} <= 3'b001;
        settle();
        chk("comp off pin", 1'b0, flt_oe);
        summarize();
    end
endmodule : switch_fault_ctrl_test
